/* File: spf_framer.sv */
/*
 * short position report framer: parses the 8-byte request from the host
 * byte stream, schedules polled or periodic reports on one-second epochs
 * and emits the 54-byte binary response; wishbone slave for control.
 * assumes rx bytes, tx handshake and epoch pulse come from logic on clk_i.
 */
// Local design decisions: the Wishbone slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "spf_regs.svh"

// Behaviour
// - rate zero gives exactly one report
// - rate N gives report every N seconds
// - response frame is exactly 54 bytes
// - clamp height and speed when both exceed
// - position may be invalid when over limit
// - filter select picks filtered or raw position
// - latitude signed mas within 324,000,000
// - longitude signed mas within 648,000,000
// - height cm from -100,000 to 1,800,000
// - sea level height always sent zero
// - speeds unsigned cm/s up to 51400
// - heading tenths of degree up to 3599
// - status bits 2-1 carry antenna sense
module spf_framer
	import spf_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	// wishbone slave
	input  wire logic               cyc_i,
	input  wire logic               stb_i,
	input  wire logic               we_i,
	input  wire logic [ADDR_W-1:0]  adr_i,
	input  wire logic [3:0]         sel_i,
	input  wire logic [31:0]        dat_i,
	output logic      [31:0]        dat_o,
	output logic                    ack_o,
	output logic                    irq_o,
	// host byte stream
	input  wire logic               rx_valid_i,
	input  wire logic [7:0]         rx_data_i,
	output logic                    tx_valid_o,
	output logic      [7:0]         tx_data_o,
	input  wire logic               tx_ready_i,
	// receiver timing
	input  wire logic               epoch_i,
	// date and time
	input  wire logic [7:0]         month_i,
	input  wire logic [7:0]         day_i,
	input  wire logic [15:0]        year_i,
	input  wire logic [7:0]         hour_i,
	input  wire logic [7:0]         minute_i,
	input  wire logic [7:0]         second_i,
	input  wire logic [31:0]        frac_ns_i,
	// position solutions
	input  wire logic signed [31:0] lat_filt_i,
	input  wire logic signed [31:0] lon_filt_i,
	input  wire logic signed [31:0] hgt_filt_i,
	input  wire logic signed [31:0] lat_raw_i,
	input  wire logic signed [31:0] lon_raw_i,
	input  wire logic signed [31:0] hgt_raw_i,
	// velocity and geometry
	input  wire logic [15:0]        speed_3d_i,
	input  wire logic [15:0]        speed_2d_i,
	input  wire logic [15:0]        heading_i,
	input  wire logic [15:0]        geometry_dilution_i,
	input  wire logic [7:0]         sats_visible_i,
	input  wire logic [7:0]         sats_tracked_i,
	// receiver status
	input  wire logic [15:0]        rcv_status_i,
	input  wire logic [1:0]         antenna_sense_i
);

	// ==========================================================
	// elaboration check
	if (ADDR_W < 5) begin : g_chk
		$error("spf_framer: ADDR_W too small for register map");
	end

	// ==========================================================
	// wishbone slave
	logic                 ack_q;
	logic [31:0]          dat_q;
	logic                 filt_sel_q;
	logic [`SPF_EV_W-1:0] ev_stat_q;
	logic [`SPF_EV_W-1:0] ev_mask_q;
	logic [47:0]          id_tag_q;
	logic [7:0]           rate_q;
	logic                 busy_w;

	wire         req_w      = cyc_i && stb_i && !ack_q;
	wire         wr_w       = req_w && we_i;
	wire [7:0]   adr8_w     = 8'(adr_i);
	wire         hit_ctrl_w = (adr8_w == `SPF_OFS_CTRL);
	wire         hit_stat_w = (adr8_w == `SPF_OFS_IRQ_STAT);
	wire         hit_mask_w = (adr8_w == `SPF_OFS_IRQ_MASK);
	wire         hit_rate_w = (adr8_w == `SPF_OFS_RATE);
	wire         hit_idlo_w = (adr8_w == `SPF_OFS_ID_LO);
	wire         hit_idhi_w = (adr8_w == `SPF_OFS_ID_HI);
	wire [31:0]  lane_w     = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	wire [31:0]  wmask_w    = dat_i & lane_w;
	// stop request cancels periodic output; the same write also loads the filter choice from bit 0
	wire         stop_w     = wr_w && hit_ctrl_w && wmask_w[`SPF_CTRL_STOP_BIT];
	wire [31:0]  id_lo_w    = id_tag_q[31:0];
	wire [31:0]  id_lo_d    = (id_lo_w & ~lane_w) | wmask_w;
	wire [15:0]  id_hi_d    = (id_tag_q[47:32] & ~lane_w[15:0]) | wmask_w[15:0];

	logic [31:0] rd_w;
	always_comb begin
		if (hit_ctrl_w) begin
			rd_w = {31'h0, filt_sel_q};
		end else if (hit_stat_w) begin
			rd_w = {29'h0, ev_stat_q};
		end else if (hit_mask_w) begin
			rd_w = {29'h0, ev_mask_q};
		end else if (hit_rate_w) begin
			rd_w = {23'h0, busy_w, rate_q};
		end else if (hit_idlo_w) begin
			rd_w = id_lo_w;
		end else if (hit_idhi_w) begin
			rd_w = {16'h0, id_tag_q[47:32]};
		end else begin
			rd_w = 32'h0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q      <= 1'b0;
			dat_q      <= 32'h0;
			filt_sel_q <= `SPF_CTRL_RST;
			ev_mask_q  <= `SPF_MASK_RST;
			id_tag_q   <= `SPF_ID_RST;
		end else begin
			ack_q <= req_w;
			dat_q <= req_w ? rd_w : 32'h0;
			if (wr_w && hit_ctrl_w && sel_i[0]) begin
				filt_sel_q <= dat_i[`SPF_CTRL_FILT_BIT];
			end
			if (wr_w && hit_mask_w && sel_i[0]) begin
				ev_mask_q <= dat_i[`SPF_EV_W-1:0];
			end
			if (wr_w && hit_idlo_w) begin
				id_tag_q[31:0] <= id_lo_d;
			end
			if (wr_w && hit_idhi_w) begin
				id_tag_q[47:32] <= id_hi_d;
			end
		end
	end

	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// ==========================================================
	// request parser
	logic [2:0] rx_idx_q;
	logic [7:0] rx_rate_q;
	logic [7:0] rx_cks_q;
	logic       rx_cks_ok_q;
	logic       acc_q;
	logic       cks_err_q;

	wire [7:0] rx_exp_w = (rx_idx_q <= 3'd1) ? `SPF_CH_AT :
	                      (rx_idx_q == 3'd2) ? `SPF_CH_H :
	                      (rx_idx_q == 3'd3) ? `SPF_CH_B :
	                      (rx_idx_q == 3'd6) ? `SPF_CH_CR : `SPF_CH_LF;
	wire       rx_free_w = (rx_idx_q == 3'd4) || (rx_idx_q == 3'd5);
	wire       rx_match_w = rx_free_w || (rx_data_i == rx_exp_w);
	wire       rx_last_w = (rx_idx_q == 3'(`SPF_REQ_LEN - 4'h1));
	wire [2:0] rx_resync_w = (rx_data_i == `SPF_CH_AT) ? 3'd1 : 3'd0;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_idx_q    <= 3'd0;
			rx_rate_q   <= 8'h0;
			rx_cks_q    <= 8'h0;
			rx_cks_ok_q <= 1'b0;
			acc_q       <= 1'b0;
			cks_err_q   <= 1'b0;
		end else begin
			acc_q     <= 1'b0;
			cks_err_q <= 1'b0;
			if (rx_valid_i) begin
				if (!rx_match_w) begin
					rx_idx_q <= rx_resync_w;
				end else if (rx_last_w) begin
					rx_idx_q  <= 3'd0;
					acc_q     <= rx_cks_ok_q;
					cks_err_q <= !rx_cks_ok_q;
				end else begin
					rx_idx_q <= rx_idx_q + 3'd1;
				end
				if (rx_idx_q == 3'd2) begin
					rx_cks_q <= rx_data_i;
				end else if (rx_idx_q <= 3'd4) begin
					rx_cks_q <= rx_cks_q ^ rx_data_i;
				end
				if (rx_idx_q == 3'd4) begin
					rx_rate_q <= rx_data_i;
				end
				if (rx_idx_q == 3'd5) begin
					rx_cks_ok_q <= (rx_data_i == rx_cks_q);
				end
			end
		end
	end

	// ==========================================================
	// report scheduling
	logic [7:0]    epoch_cnt_q;
	logic          pend_q;
	spf_tx_state_t tx_state_q;

	wire [7:0] epoch_nxt_w = epoch_cnt_q + 8'd1;
	wire       periodic_w  = (rate_q != 8'h0);
	wire       due_w       = epoch_i && periodic_w && (epoch_nxt_w == rate_q);
	wire       start_w     = pend_q && (tx_state_q == SPF_TX_IDLE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rate_q      <= 8'h0;
			epoch_cnt_q <= 8'h0;
			pend_q      <= 1'b0;
		end else begin
			if (acc_q) begin
				rate_q      <= rx_rate_q;
				epoch_cnt_q <= 8'h0;
			end else if (stop_w) begin
				rate_q <= 8'h0;
			end else if (epoch_i && periodic_w) begin
				epoch_cnt_q <= due_w ? 8'h0 : epoch_nxt_w;
			end
			// a new trigger in the start cycle wins over the clear
			if (acc_q || due_w) begin
				pend_q <= 1'b1;
			end else if (start_w) begin
				pend_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// field conditioning
	wire signed [31:0] lat_w = filt_sel_q ? lat_filt_i : lat_raw_i;
	wire signed [31:0] lon_w = filt_sel_q ? lon_filt_i : lon_raw_i;
	wire signed [31:0] hgt_w = filt_sel_q ? hgt_filt_i : hgt_raw_i;
	wire over_w = (hgt_w > `SPF_HGT_MAX) && (speed_3d_i > `SPF_SPD_MAX);

	// position is passed on clamped only; it is not trusted when over_w holds
	wire signed [31:0] lat_c = (lat_w > `SPF_LAT_MAX) ? `SPF_LAT_MAX :
	                           (lat_w < -`SPF_LAT_MAX) ? -`SPF_LAT_MAX : lat_w;
	wire signed [31:0] lon_c = (lon_w > `SPF_LON_MAX) ? `SPF_LON_MAX :
	                           (lon_w < -`SPF_LON_MAX) ? -`SPF_LON_MAX : lon_w;
	wire signed [31:0] hgt_c = (over_w || hgt_w > `SPF_HGT_MAX) ? `SPF_HGT_MAX :
	                           (hgt_w < `SPF_HGT_MIN) ? `SPF_HGT_MIN : hgt_w;
	wire [15:0] spd3_c = (over_w || speed_3d_i > `SPF_SPD_MAX) ? `SPF_SPD_MAX : speed_3d_i;
	wire [15:0] spd2_c = (over_w || speed_2d_i > `SPF_SPD_MAX) ? `SPF_SPD_MAX : speed_2d_i;
	wire [15:0] hdg_c  = (heading_i > `SPF_HDG_MAX) ? `SPF_HDG_MAX : heading_i;
	wire [15:0] stat_c = {rcv_status_i[15:13], 2'b00, rcv_status_i[10:3],
	                      antenna_sense_i, rcv_status_i[0]};

	// whole response, byte 0 in the top bits; checksum slot filled at send time
	wire [`SPF_RSP_LEN*8-1:0] frame_w = {
		`SPF_CH_AT, `SPF_CH_AT, `SPF_CH_H, `SPF_CH_B,
		month_i, day_i, year_i, hour_i, minute_i, second_i, frac_ns_i,
		lat_c, lon_c, hgt_c,
		32'h0,
		spd3_c, spd2_c, hdg_c, geometry_dilution_i,
		sats_visible_i, sats_tracked_i, stat_c, 16'h0,
		id_tag_q, 8'h0, `SPF_CH_CR, `SPF_CH_LF};

	// ==========================================================
	// response transmitter
	logic [`SPF_RSP_LEN*8-1:0] frame_q;
	logic [5:0]                tx_idx_q;
	logic [7:0]                tx_cks_q;
	logic [7:0]                tx_data_q;
	logic                      tx_valid_q;
	logic                      sent_q;

	wire [8:0] tx_bit_w  = {6'(`SPF_RSP_LEN - 6'h1 - tx_idx_q), 3'b000};
	wire [7:0] tx_byte_w = frame_q[tx_bit_w +: 8];
	wire       is_cks_w  = (tx_idx_q == `SPF_RSP_CKS_IDX);
	wire       in_cks_w  = (tx_idx_q >= `SPF_CKS_FIRST_IDX) && !is_cks_w && !(tx_idx_q > `SPF_RSP_CKS_IDX);
	wire       tx_fire_w = tx_valid_q && tx_ready_i;
	wire       tx_end_w  = (tx_idx_q == `SPF_RSP_LEN - 6'h1);

	assign busy_w = (tx_state_q != SPF_TX_IDLE);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tx_state_q <= SPF_TX_IDLE;
			frame_q    <= '0;
			tx_idx_q   <= 6'h0;
			tx_cks_q   <= 8'h0;
			tx_data_q  <= 8'h0;
			tx_valid_q <= 1'b0;
			sent_q     <= 1'b0;
		end else begin
			sent_q <= 1'b0;
			case (tx_state_q)
				SPF_TX_IDLE: begin
					if (start_w) begin
						frame_q    <= frame_w;
						tx_idx_q   <= 6'h0;
						tx_cks_q   <= 8'h0;
						tx_state_q <= SPF_TX_LOAD;
					end
				end
				SPF_TX_LOAD: begin
					tx_data_q  <= is_cks_w ? tx_cks_q : tx_byte_w;
					tx_valid_q <= 1'b1;
					if (in_cks_w) begin
						tx_cks_q <= tx_cks_q ^ tx_byte_w;
					end
					tx_state_q <= SPF_TX_SEND;
				end
				SPF_TX_SEND: begin
					if (tx_fire_w) begin
						tx_valid_q <= 1'b0;
						tx_idx_q   <= tx_idx_q + 6'h1;
						if (tx_end_w) begin
							tx_state_q <= SPF_TX_IDLE;
							sent_q     <= 1'b1;
						end else begin
							tx_state_q <= SPF_TX_LOAD;
						end
					end
				end
				default: begin
					tx_state_q <= SPF_TX_IDLE;
				end
			endcase
		end
	end

	assign tx_valid_o = tx_valid_q;
	assign tx_data_o  = tx_data_q;

	// ==========================================================
	// interrupts
	logic irq_q;
	wire [`SPF_EV_W-1:0] ev_set_w = {sent_q, cks_err_q, acc_q};
	wire [`SPF_EV_W-1:0] ev_clr_w = (wr_w && hit_stat_w && sel_i[0]) ?
	                                dat_i[`SPF_EV_W-1:0] : {`SPF_EV_W{1'b0}};
	// a set in the clearing cycle wins so no event is lost
	wire [`SPF_EV_W-1:0] ev_stat_d = (ev_stat_q & ~ev_clr_w) | ev_set_w;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ev_stat_q <= {`SPF_EV_W{1'b0}};
			irq_q     <= 1'b0;
		end else begin
			ev_stat_q <= ev_stat_d;
			irq_q     <= |(ev_stat_d & ev_mask_q);
		end
	end

	assign irq_o = irq_q;

endmodule
`default_nettype wire

/* File: spf_framer_monitor.sv */
/* checker for the framer ports: bus timing, tx hold and frame shape.
 * assumes it is bound to spf_framer, all on clk_i. */
`timescale 1ns/10ps
`default_nettype none
module spf_framer_monitor #(
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic              clk_i,
	input wire logic              rst_i,
	// wishbone
	input wire logic              cyc_i,
	input wire logic              stb_i,
	input wire logic              we_i,
	input wire logic [ADDR_W-1:0] adr_i,
	input wire logic [3:0]        sel_i,
	input wire logic [31:0]       dat_i,
	input wire logic [31:0]       dat_o,
	input wire logic              ack_o,
	input wire logic              irq_o,
	// report stream
	input wire logic              tx_valid_o,
	input wire logic [7:0]        tx_data_o,
	input wire logic              tx_ready_i
);
	// =====================================
	// byte position and running checksum
	logic [5:0] idx_q;
	logic [7:0] xor_q;
	wire        take = tx_valid_o && tx_ready_i;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			idx_q <= 6'h00;
			xor_q <= 8'h00;
		end else if (take) begin
			idx_q <= (idx_q == 6'h35) ? 6'h00 : idx_q + 6'h01;
			xor_q <= (idx_q < 6'h02) ? 8'h00 : xor_q ^ tx_data_o;
		end
	end
	// =====================================
	// properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req; cyc_i && stb_i && !ack_o; endsequence
	sequence s_stall; tx_valid_o && !tx_ready_i; endsequence
	a_ack_next: assert property (s_req |=> ack_o)
		else $error("request not acked next cycle");
	a_ack_pulse: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data without ack");
	a_tx_hold: assert property (s_stall |=> tx_valid_o && $stable(tx_data_o))
		else $error("tx byte dropped or changed while stalled");
	a_frame_head: assert property (take && idx_q < 6'h02 |-> tx_data_o == 8'h40)
		else $error("bad frame start");
	a_frame_tag: assert property (take && idx_q inside {6'h02, 6'h03} |->
		tx_data_o == (idx_q[0] ? 8'h62 : 8'h48)) else $error("bad frame type");
	a_frame_tail: assert property (take && idx_q >= 6'h34 |->
		tx_data_o == (idx_q[0] ? 8'h0a : 8'h0d)) else $error("bad frame end");
	a_sea_zero: assert property (take && idx_q inside {[6'h1b:6'h1e]} |-> tx_data_o == 8'h00)
		else $error("sea level height not zero");
	a_frame_cks: assert property (take && idx_q == 6'h33 |-> tx_data_o == xor_q)
		else $error("bad report checksum");
	// mask cleared: the line must fall within the register pipeline delay
	a_irq_masked: assert property (ack_o && we_i && adr_i == 8'h08 && sel_i[0]
		&& dat_i[2:0] == 3'h0 |-> ##3 !irq_o) else $error("irq with empty mask");
endmodule
`default_nettype wire

/* File: spf_host_model.sv */
/* host model: sends request frames and sinks report bytes, stalling
 * half the time when slow_i is high. assumes the framer's clock. */
`timescale 1ns/10ps
`default_nettype none
module spf_host_model (
	// clock
	input  wire logic       clk_i,
	// request stream
	output logic            rx_valid_o,
	output logic [7:0]      rx_data_o,
	// report stream
	input  wire logic       tx_valid_i,
	input  wire logic [7:0] tx_data_i,
	output logic            tx_ready_o,
	input  wire logic       slow_i
);
	logic [1:0] stall_q = 2'h0;
	logic [7:0] rsp_q[$];
	initial begin
		rx_valid_o = 1'b0;
		rx_data_o = 8'h00;
	end
	always @(posedge clk_i) stall_q <= stall_q + 2'h1;
	assign tx_ready_o = !slow_i || stall_q[1];
	always @(posedge clk_i) if (tx_valid_i && tx_ready_o) rsp_q.push_back(tx_data_i);
	// bad flips the checksum so the frame must be dropped
	task automatic send(input logic [7:0] rate, input logic bad);
		logic [7:0] f[8];
		f = '{8'h40, 8'h40, 8'h48, 8'h62, rate, 8'h2a ^ rate ^ {7'h0, bad}, 8'h0d, 8'h0a};
		foreach (f[i]) begin
			@(posedge clk_i);
			rx_valid_o <= 1'b1;
			rx_data_o <= f[i];
		end
		@(posedge clk_i);
		rx_valid_o <= 1'b0;
		rx_data_o <= 8'hf5; // idle line shows the inverse of the last byte
	endtask
endmodule
`default_nettype wire

/* File: spf_pkg.sv */
/*
 * types shared by the short position report framer.
 * assumes nothing of its surroundings.
 */
package spf_pkg;
	typedef enum logic [1:0] {
		SPF_TX_IDLE,
		SPF_TX_LOAD,
		SPF_TX_SEND
	} spf_tx_state_t;

	typedef logic [7:0] spf_byte_t;
endpackage

/* File: spf_regs.svh */
/*
 * register offsets, field positions, reset values, frame layout and limits
 * of the short position report framer.
 * assumes byte-addressed classic wishbone with 32-bit data.
 */
`ifndef SPF_REGS_SVH
`define SPF_REGS_SVH

// ==========================================================
// register byte offsets
`define SPF_OFS_CTRL     8'h00
`define SPF_OFS_IRQ_STAT 8'h04
`define SPF_OFS_IRQ_MASK 8'h08
`define SPF_OFS_RATE     8'h0c
`define SPF_OFS_ID_LO    8'h10
`define SPF_OFS_ID_HI    8'h14

// ==========================================================
// field positions and reset values
`define SPF_CTRL_FILT_BIT  0
`define SPF_CTRL_STOP_BIT  1
`define SPF_EV_REQ_BIT     0
`define SPF_EV_CKS_BIT     1
`define SPF_EV_SENT_BIT    2
`define SPF_EV_W           3
`define SPF_RATE_BUSY_BIT  8
`define SPF_CTRL_RST       1'b1
`define SPF_MASK_RST       3'h0
`define SPF_ID_RST         48'h202020202020

// ==========================================================
// frame layout
`define SPF_REQ_LEN        4'h8
`define SPF_RSP_LEN        6'h36
`define SPF_RSP_CKS_IDX    6'h33
`define SPF_CKS_FIRST_IDX  6'h02
`define SPF_CH_AT          8'h40
`define SPF_CH_H           8'h48
`define SPF_CH_B           8'h62
`define SPF_CH_CR          8'h0d
`define SPF_CH_LF          8'h0a

// ==========================================================
// field limits
`define SPF_LAT_MAX        32'sd324000000
`define SPF_LON_MAX        32'sd648000000
`define SPF_HGT_MAX        32'sd1800000
`define SPF_HGT_MIN        -32'sd100000
`define SPF_SPD_MAX        16'd51400
`define SPF_HDG_MAX        16'd3599

`endif

/* File: tb_top.sv */
/* top testbench of the framer: bus tasks, scenarios and verdict.
 * assumes the framer, its monitor and the host model. */
`timescale 1ns/10ps
`default_nettype none
`include "spf_regs.svh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin miscompares++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
	localparam int ADDR_W = 8;
	logic              clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
	logic              we_i = 1'b0, epoch_i = 1'b0, ack_o, irq_o, rx_v, tx_v, tx_r;
	logic [7:0]        adr_i = 8'h00, rx_d, tx_d;
	logic [31:0]       dat_i = 32'h0, dat_o, rd;
	logic [71:0]       stamp = 72'h071e07e80c2d1e0000;
	logic signed [31:0] lat_r = 32'sd0, lon_r = 32'sd0, hgt_r = 32'sd0;
	logic signed [31:0] lat_f = 32'sd1000, lon_f = -32'sd2000, hgt_f = 32'sd5000;
	logic [15:0]       spd3 = 16'd60000, spd2 = 16'd100, hdg = 16'd4000;
	logic [3:0]        sel_i = 4'hf, wsel = 4'hf;
	logic [1:0]        ant = 2'b10;
	logic              slow = 1'b1;
	int                miscompares = 0, check_count = 0;
	always #12.5 clk_i = ~clk_i;
	spf_framer i_spf_framer (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.irq_o(irq_o), .rx_valid_i(rx_v), .rx_data_i(rx_d), .tx_valid_o(tx_v), .tx_data_o(tx_d),
		.tx_ready_i(tx_r), .epoch_i(epoch_i), .month_i(stamp[71:64]), .day_i(stamp[63:56]),
		.year_i(stamp[55:40]), .hour_i(stamp[39:32]), .minute_i(stamp[31:24]),
		.second_i(stamp[23:16]), .frac_ns_i({16'h0, stamp[15:0]}), .lat_filt_i(lat_f),
		.lon_filt_i(lon_f), .hgt_filt_i(hgt_f), .lat_raw_i(lat_r), .lon_raw_i(lon_r),
		.hgt_raw_i(hgt_r), .speed_3d_i(spd3), .speed_2d_i(spd2), .heading_i(hdg),
		.geometry_dilution_i(16'h0123), .sats_visible_i(8'h09), .sats_tracked_i(8'h07),
		.rcv_status_i(16'hffff), .antenna_sense_i(ant));
	spf_host_model i_host (.clk_i(clk_i), .rx_valid_o(rx_v), .rx_data_o(rx_d),
		.tx_valid_i(tx_v), .tx_data_i(tx_d), .tx_ready_o(tx_r), .slow_i(slow));
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, wsel};
		do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 50);
		if (n >= 50) miscompares++;
		rd = dat_o;
		{cyc_i, stb_i, we_i} <= 3'b000;
	endtask
	task automatic wait_bytes(input int n);
		for (int i = 0; i < 3000 && i_host.rsp_q.size() < n; i++) @(posedge clk_i);
	endtask
	task automatic epochs(input int n);
		repeat (n) begin
			repeat (300) @(posedge clk_i);
			epoch_i <= 1'b1;
			@(posedge clk_i);
			epoch_i <= 1'b0;
		end
	endtask
	function automatic logic [31:0] get32(input int b);
		return {i_host.rsp_q[b], i_host.rsp_q[b+1], i_host.rsp_q[b+2], i_host.rsp_q[b+3]};
	endfunction
	task automatic t_regs;
		wb(0, `SPF_OFS_CTRL, 0); `CHK(rd, 32'h1)
		wb(0, `SPF_OFS_ID_LO, 0); `CHK(rd, 32'h20202020)
		wb(0, `SPF_OFS_ID_HI, 0); `CHK(rd, 32'h2020)
		wb(1, `SPF_OFS_ID_HI, 32'h00004546);
		wb(0, `SPF_OFS_ID_HI, 0); `CHK(rd, 32'h4546)
		wsel = 4'h1;
		wb(1, `SPF_OFS_ID_LO, 32'hffffff41);
		wsel = 4'hf;
		wb(0, `SPF_OFS_ID_LO, 0); `CHK(rd, 32'h20202041)
		wb(1, 8'h20, 32'hffffffff);
		wb(0, 8'h20, 0); `CHK(rd, 32'h0)
		$display("test regs done");
	endtask
	task automatic t_poll;
		logic [7:0] x = 8'h00;
		i_host.rsp_q.delete();
		wb(1, `SPF_OFS_IRQ_MASK, 32'h4);
		i_host.send(8'h00, 1'b0);
		wait_bytes(54);
		`CHK(get32(0), 32'h40404862)
		`CHK(get32(4), 32'h071e07e8)
		`CHK(get32(8), 32'h0c2d1e00)
		`CHK(get32(15), 32'd1000)
		`CHK(get32(19), -32'sd2000)
		`CHK(get32(23), 32'd5000)
		`CHK(get32(31), {16'd51400, 16'd100})
		`CHK(get32(35), {16'd3599, 16'h0123})
		`CHK(get32(41), 32'he7fd0000)
		`CHK(get32(45), 32'h45462020)
		`CHK(get32(47), 32'h20202041)
		for (int i = 2; i < 51; i++) x ^= i_host.rsp_q[i];
		`CHK(i_host.rsp_q[51], x)
		epochs(3);
		`CHK(i_host.rsp_q.size(), 54)
		wb(0, `SPF_OFS_IRQ_STAT, 0); `CHK(rd, 32'h5)
		`CHK(irq_o, 1'b1)
		wb(1, `SPF_OFS_IRQ_STAT, 32'h7);
		repeat (3) @(posedge clk_i);
		`CHK(irq_o, 1'b0)
		wb(1, `SPF_OFS_IRQ_MASK, 0);
		$display("test poll done");
	endtask
	task automatic t_bad;
		i_host.rsp_q.delete();
		i_host.send(8'h01, 1'b1);
		epochs(1);
		`CHK(i_host.rsp_q.size(), 0)
		wb(0, `SPF_OFS_IRQ_STAT, 0); `CHK(rd, 32'h2)
		wb(1, `SPF_OFS_IRQ_STAT, 32'h7);
		$display("test bad checksum done");
	endtask
	task automatic t_period;
		i_host.rsp_q.delete();
		i_host.send(8'h02, 1'b0);
		wait_bytes(54);
		wb(0, `SPF_OFS_RATE, 0); `CHK(rd[7:0], 8'h02)
		epochs(1);
		`CHK(i_host.rsp_q.size(), 54)
		epochs(1);
		wait_bytes(108);
		epochs(2);
		wait_bytes(162);
		`CHK(i_host.rsp_q.size(), 162)
		wb(1, `SPF_OFS_CTRL, 32'h3);
		epochs(3);
		`CHK(i_host.rsp_q.size(), 162)
		$display("test periodic done");
	endtask
	task automatic t_clamp;
		i_host.rsp_q.delete();
		{lat_r, lon_r, hgt_r} <= {32'sd400000000, -32'sd700000000, 32'sd2000000};
		ant <= 2'b01;
		slow <= 1'b0;
		wb(1, `SPF_OFS_CTRL, 0);
		i_host.send(8'h00, 1'b0);
		wait_bytes(54);
		`CHK(get32(15), 32'sd324000000)
		`CHK(get32(19), -32'sd648000000)
		`CHK(get32(23), 32'sd1800000)
		`CHK(get32(31), {2{16'd51400}})
		`CHK(get32(41), 32'he7fb0000)
		$display("test clamp done");
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_poll();
		t_bad();
		t_period();
		t_clamp();
		results();
	end
	// watchdog: about four times the expected run
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		results();
	end
endmodule
bind spf_framer spf_framer_monitor #(.ADDR_W(ADDR_W)) i_spf_framer_monitor (.clk_i(clk_i),
	.rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
	.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .tx_valid_o(tx_valid_o),
	.tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i));
`default_nettype wire
